/* File: hdl/fsps_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module fsps_sequencer import fsps_pkg::*; #(
   parameter int WORD_BITS = 6,
   parameter int PAGE_BITS = 8,
   parameter int NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = 224,
   parameter logic [15:0] BOOT_RESET_VECTOR = 16'h3800,
   parameter int PROG_CYCLES = PROG_MIN_CYC + (PROG_MAX_CYC - PROG_MIN_CYC) / 2
) (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   // fuse pin, read-only here
   input wire logic boot_reset_select_fuse,
   // control register write from the core
   input wire logic csr_wr,
   input wire logic [7:0] csr_wdata,
   output logic [7:0] self_program_control_status,
   // store-program instruction
   input wire logic spm_exec,
   input wire fsps_spm_req_t spm_req,
   // program memory byte read
   input wire logic [15:0] lpm_addr,
   output logic lpm_byte_hi,
   output logic [15:0] lpm_word_addr,
   // EEPROM write in progress
   input wire logic eeprom_write,
   // core control
   output logic [15:0] reset_vector,
   output logic cpu_halt,
   output logic rww_read_block,
   output logic spm_irq,
   // flash array side
   output fsps_op_t flash_op,
   output logic flash_strobe,
   output logic [15:0] flash_wdata,
   output logic [WORD_BITS-1:0] flash_widx,
   output logic [(1<<WORD_BITS)-1:0] buf_valid
);
   typedef enum logic [2:0] {
      FS_IDLE = 3'b001,
      FS_ARMED = 3'b010,
      FS_PROG = 3'b100
   } fsps_state_t;

   fsps_state_t state, next_state;
   logic [7:0] csr, next_csr;
   logic [2:0] arm_cnt, next_arm_cnt;
   logic [31:0] prog_cnt, next_prog_cnt;
   fsps_op_t op, next_op;
   logic busy, next_busy;
   logic halt, next_halt;
   logic strobe, next_strobe;
   logic buf_clear, buf_load;
   logic fuse_s1, fuse_s2, ee_s1, ee_s2;
   logic [15:0] next_vector;
   logic [15:0] buf_rd;

   function automatic logic in_no_read_while_write_area(input logic [15:0] z);
      logic [PAGE_BITS-1:0] pg;
      // bit zero picks the byte, so the word field sits one bit up
      pg = z[WORD_BITS + 1 +: PAGE_BITS];
      return 32'(pg) >= NO_READ_WHILE_WRITE_AREA_FIRST_PAGE;
   endfunction : in_no_read_while_write_area

   // fuse and EEPROM write pins pass two flops before use
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         fuse_s1 <= 1'b1;
         fuse_s2 <= 1'b1;
         ee_s1 <= 1'b0;
         ee_s2 <= 1'b0;
      end else if (ce) begin
         fuse_s1 <= boot_reset_select_fuse;
         fuse_s2 <= fuse_s1;
         ee_s1 <= eeprom_write;
         ee_s2 <= ee_s1;
      end
   end

   // fuse is only sampled, never driven: no write path exists
   always_comb begin
      next_vector = fuse_s2 ? APP_RESET_VECTOR : BOOT_RESET_VECTOR;
   end

   always_comb begin
      next_state = state;
      next_csr = csr;
      next_arm_cnt = arm_cnt;
      next_prog_cnt = prog_cnt;
      next_op = op;
      next_busy = busy;
      next_halt = halt;
      next_strobe = 1'b0;
      buf_clear = 1'b0;
      buf_load = 1'b0;
      if (ee_s2) begin
         buf_clear = 1'b1;
      end
      case (state)
         FS_IDLE: begin
            // eeprom write blocks arming of flash commands
            if (csr_wr && !ee_s2) begin
               next_csr = {csr_wdata[7], busy, 1'b0, csr_wdata[4:0]};
               if (csr_wdata[CSR_CMD_EN_BIT]) begin
                  next_state = FS_ARMED;
                  next_arm_cnt = ARM_WINDOW;
               end
            end
         end
         FS_ARMED: begin
            if (spm_exec) begin
               next_state = FS_IDLE;
               next_csr[4:0] = 5'h00;
               case (csr[4:0])
                  CMD_LOAD: begin
                     buf_load = !ee_s2;
                  end
                  CMD_ERASE, CMD_WRITE: begin
                     next_op.erase = (csr[4:0] == CMD_ERASE);
                     next_op.write = (csr[4:0] == CMD_WRITE);
                     next_op.lock = 1'b0;
                     // page field only; word bits forced to zero
                     next_op.addr = {spm_req.z_ptr[15:WORD_BITS+1], {(WORD_BITS+1){1'b0}}};
                     next_busy = 1'b1;
                     next_halt = in_no_read_while_write_area(spm_req.z_ptr);
                     next_strobe = 1'b1;
                     next_prog_cnt = 32'(PROG_CYCLES);
                     next_csr[CSR_CMD_EN_BIT] = 1'b1;
                     next_csr[CSR_BUSY_BIT] = 1'b1;
                     next_state = FS_PROG;
                  end
                  CMD_LOCK: begin
                     next_op.erase = 1'b0;
                     next_op.write = 1'b0;
                     next_op.lock = 1'b1;
                     next_op.addr = 16'h0000;
                     next_halt = 1'b0;
                     next_strobe = 1'b1;
                     next_prog_cnt = 32'(PROG_CYCLES);
                     next_csr[CSR_CMD_EN_BIT] = 1'b1;
                     next_state = FS_PROG;
                  end
                  CMD_REEN: begin
                     buf_clear = 1'b1;
                     next_busy = 1'b0;
                     next_csr[CSR_BUSY_BIT] = 1'b0;
                  end
                  default: begin
                  end
               endcase
            end else if (arm_cnt == 3'h1) begin
               next_state = FS_IDLE;
               next_csr[4:0] = 5'h00;
            end else begin
               next_arm_cnt = arm_cnt - 3'h1;
            end
         end
         FS_PROG: begin
            if (csr_wr) begin
               next_csr[CSR_IRQ_EN_BIT] = csr_wdata[CSR_IRQ_EN_BIT];
            end
            if (prog_cnt == 32'h1) begin
               if (op.write) begin
                  buf_clear = 1'b1;
               end
               next_csr[4:0] = 5'h00;
               next_halt = 1'b0;
               next_op = '0;
               next_state = FS_IDLE;
            end else begin
               next_prog_cnt = prog_cnt - 32'h1;
            end
         end
         default: begin
            next_state = FS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state <= FS_IDLE;
         csr <= CSR_RESET;
         arm_cnt <= 3'h0;
         prog_cnt <= 32'h0;
         op <= '0;
         busy <= 1'b0;
         halt <= 1'b0;
         strobe <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         csr <= next_csr;
         arm_cnt <= next_arm_cnt;
         prog_cnt <= next_prog_cnt;
         op <= next_op;
         busy <= next_busy;
         halt <= next_halt;
         strobe <= next_strobe;
      end
   end

   fsps_page_buffer #(.WORD_BITS(WORD_BITS)) u_buf (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .clear(buf_clear),
      .load(buf_load),
      .load_idx(spm_req.z_ptr[WORD_BITS:1]),
      .load_data(spm_req.data),
      .rd_idx(flash_widx),
      .rd_data(buf_rd),
      .valid(buf_valid)
   );

   // registered outputs
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         self_program_control_status <= CSR_RESET;
         reset_vector <= APP_RESET_VECTOR;
         cpu_halt <= 1'b0;
         rww_read_block <= 1'b0;
         spm_irq <= 1'b0;
         flash_op <= '0;
         flash_strobe <= 1'b0;
         flash_wdata <= 16'h0000;
         flash_widx <= '0;
         lpm_byte_hi <= 1'b0;
         lpm_word_addr <= 16'h0000;
      end else if (ce) begin
         self_program_control_status <= next_csr;
         reset_vector <= next_vector;
         cpu_halt <= next_halt;
         rww_read_block <= next_busy;
         spm_irq <= next_csr[CSR_IRQ_EN_BIT] && !next_csr[CSR_CMD_EN_BIT];
         flash_op <= next_op;
         flash_strobe <= next_strobe;
         // array walks the buffer while any erase, write or lock op runs in FS_PROG
         flash_widx <= (state == FS_PROG) ? flash_widx + 1'b1 : '0;
         flash_wdata <= buf_rd;
         lpm_byte_hi <= lpm_addr[0];
         lpm_word_addr <= {1'b0, lpm_addr[15:1]};
      end
   end
endmodule : fsps_sequencer
`default_nettype wire

/* File: hdl/fsps_pkg.sv */
package fsps_pkg;
   // control/status bit positions
   localparam int CSR_CMD_EN_BIT = 0;
   localparam int CSR_PG_ERASE_BIT = 1;
   localparam int CSR_PG_WRITE_BIT = 2;
   localparam int CSR_LOCK_SET_BIT = 3;
   localparam int CSR_REENABLE_BIT = 4;
   localparam int CSR_BUSY_BIT = 6;
   localparam int CSR_IRQ_EN_BIT = 7;
   // command codes in the low five bits
   localparam logic [4:0] CMD_LOAD = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_LOCK = 5'h09;
   localparam logic [4:0] CMD_REEN = 5'h11;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [15:0] APP_RESET_VECTOR = 16'h0000;
   // arm window in cycles after the control write
   localparam logic [2:0] ARM_WINDOW = 3'h4;
   // programming time in microseconds, and in cycles at CLK_MHZ
   localparam int CLK_MHZ = 10;
   localparam int PROG_MIN_US = 3700;
   localparam int PROG_MAX_US = 4500;
   localparam int PROG_MIN_CYC = PROG_MIN_US * CLK_MHZ;
   localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;

   typedef struct packed {
      logic [15:0] z_ptr;
      logic [15:0] data;
   } fsps_spm_req_t;

   typedef struct packed {
      logic erase;
      logic write;
      logic lock;
      logic [15:0] addr;
   } fsps_op_t;
endpackage : fsps_pkg

/* File: hdl/fsps_page_buffer.sv */
`timescale 1ns/1ns
`default_nettype none
module fsps_page_buffer import fsps_pkg::*; #(
   parameter int WORD_BITS = 6
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   // load and clear
   input wire logic clear,
   input wire logic load,
   input wire logic [WORD_BITS-1:0] load_idx,
   input wire logic [15:0] load_data,
   // read back for the flash array
   input wire logic [WORD_BITS-1:0] rd_idx,
   output logic [15:0] rd_data,
   output logic [(1<<WORD_BITS)-1:0] valid
);
   localparam int DEPTH = 1 << WORD_BITS;
   logic [15:0] mem [DEPTH];
   logic [DEPTH-1:0] next_valid;

   always_comb begin
      next_valid = valid;
      if (clear) begin
         next_valid = '0;
      end else if (load) begin
         next_valid[load_idx] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         valid <= '0;
      end else if (ce) begin
         valid <= next_valid;
      end
   end

   // storage is not reset; erased entries are masked by valid and read as blank
   always_ff @(posedge clk_sys) begin
      if (ce && load && !clear) begin
         mem[load_idx] <= load_data;
      end
   end

   assign rd_data = valid[rd_idx] ? mem[rd_idx] : 16'hFFFF;
endmodule : fsps_page_buffer
`default_nettype wire

/* File: testbench/fsps_sequencer_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module fsps_seq_checker import fsps_pkg::*; #(
   parameter int PROG_CYCLES = 20,
   parameter int NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = 224
) (
   // clock, reset, core side
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic spm_exec,
   input wire fsps_spm_req_t spm_req,
   input wire logic [7:0] self_program_control_status,
   input wire logic [15:0] lpm_addr,
   input wire logic lpm_byte_hi,
   input wire logic [15:0] lpm_word_addr,
   input wire logic eeprom_write,
   input wire logic cpu_halt,
   input wire logic rww_read_block,
   input wire logic spm_irq,
   // flash side
   input wire fsps_op_t flash_op,
   input wire logic flash_strobe,
   input wire logic [63:0] buf_valid
);
   localparam int P_LO = PROG_CYCLES - 2;
   localparam int P_HI = PROG_CYCLES + 3;
   logic [7:0] st;
   assign st = self_program_control_status;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_arm;
      spm_exec && st[0] && (st[1] || st[2]) && !rww_read_block;
   endsequence
   sequence s_hold;
      (st[0] && $stable(flash_op.addr))[*8];
   endsequence
   property p_start;
      s_arm |=> flash_strobe && rww_read_block && st[6];
   endproperty
   a_start: assert property (p_start) else $error("no op start");
   property p_hold;
      flash_strobe && !flash_op.lock |=> s_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("op not held");
   property p_len;
      flash_strobe && !flash_op.lock |-> ##[P_LO:P_HI] $fell(st[0]);
   endproperty
   a_len: assert property (p_len) else $error("op length");
   property p_halt;
      flash_strobe && !flash_op.lock
         |-> cpu_halt == ($past(spm_req.z_ptr[15:7]) >= NO_READ_WHILE_WRITE_AREA_FIRST_PAGE);
   endproperty
   a_halt: assert property (p_halt) else $error("halt wrong");
   property p_irq;
      st[7] && !st[0] |-> ##[0:1] spm_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_selfclr;
      $rose(st[0]) ##0 (!spm_exec)[*5] |-> ##[0:1] !st[0];
   endproperty
   a_selfclr: assert property (p_selfclr) else $error("arm kept");
   property p_lpm;
      1 |=> lpm_byte_hi == $past(lpm_addr[0]) && lpm_word_addr == $past(lpm_addr) >> 1;
   endproperty
   a_lpm: assert property (p_lpm) else $error("byte read addr");
   property p_eeclr;
      eeprom_write[*4] |-> buf_valid == '0;
   endproperty
   a_eeclr: assert property (p_eeclr) else $error("buffer kept");
   property p_reen;
      $fell(rww_read_block) |-> $past(spm_exec) || $past(spm_exec, 2);
   endproperty
   a_reen: assert property (p_reen) else $error("busy cleared alone");
endmodule : fsps_seq_checker
bind fsps_sequencer fsps_seq_checker #(.PROG_CYCLES(PROG_CYCLES),
   .NO_READ_WHILE_WRITE_AREA_FIRST_PAGE(NO_READ_WHILE_WRITE_AREA_FIRST_PAGE)) u_chk (.clk_sys, .rstn, .spm_exec, .spm_req,
   .self_program_control_status, .lpm_addr, .lpm_byte_hi, .lpm_word_addr, .eeprom_write,
   .cpu_halt, .rww_read_block, .spm_irq, .flash_op, .flash_strobe, .buf_valid);
`default_nettype wire

/* File: testbench/fsps_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fsps_core_model import fsps_pkg::*; (
   // clock
   input wire logic clk_sys,
   // control write and store
   output logic csr_wr,
   output logic [7:0] csr_wdata,
   output logic spm_exec,
   output fsps_spm_req_t spm_req
);
   initial begin
      csr_wr = 1'b0;
      csr_wdata = 8'h00;
      spm_exec = 1'b0;
      spm_req = '0;
   end
   // gap 0 arms and never stores
   task automatic spm(input logic [7:0] code, input logic [15:0] z, input logic [15:0] d,
      input int gap);
      @(negedge clk_sys);
      csr_wr = 1'b1;
      csr_wdata = code;
      @(negedge clk_sys);
      csr_wr = 1'b0;
      repeat (gap > 0 ? gap - 1 : 5) @(negedge clk_sys);
      if (gap > 0) begin
         spm_req = {z, d};
         spm_exec = 1'b1;
         @(negedge clk_sys);
         spm_exec = 1'b0;
         // pointer is reused at once, the op must not follow it
         spm_req = ~spm_req;
      end
   endtask : spm
endmodule : fsps_core_model
`default_nettype wire

/* File: testbench/flash_self_program_sequencer_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_self_program_sequencer_bench import fsps_pkg::*;;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic fuse = 1'b1;
   logic eeprom_write = 1'b0;
   logic [15:0] lpm_addr = 16'h0000;
   logic csr_wr, spm_exec, lpm_byte_hi, cpu_halt, rww_read_block, spm_irq, flash_strobe;
   logic [7:0] csr_wdata, st;
   logic [15:0] lpm_word_addr, reset_vector;
   logic [63:0] buf_valid;
   logic [15:0] flash_wdata;
   logic [5:0] flash_widx;
   fsps_spm_req_t spm_req;
   fsps_op_t flash_op;
   int error_cnt = 0;
   int comparisons = 0;
   always #50 clk_sys = ~clk_sys;
   fsps_core_model u_core (.clk_sys, .csr_wr, .csr_wdata, .spm_exec, .spm_req);
   fsps_sequencer #(.PROG_CYCLES(20), .BOOT_RESET_VECTOR(16'h1C00)) u_dut (.clk_sys,
      .rstn, .ce(1'b1), .boot_reset_select_fuse(fuse), .csr_wr, .csr_wdata,
      .self_program_control_status(st), .spm_exec, .spm_req, .lpm_addr, .lpm_byte_hi,
      .lpm_word_addr, .eeprom_write, .reset_vector, .cpu_halt, .rww_read_block, .spm_irq,
      .flash_op, .flash_strobe, .flash_wdata, .flash_widx, .buf_valid);
   // wide enough that no packed group of outputs loses its top bits
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("%0d compares, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic wait_done;
      int n;
      n = 0;
      while (st[0] !== 1'b0 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      chk(n < 100, 1);
   endtask : wait_done
   task automatic load2;
      u_core.spm(8'h01, 16'h0286, 16'hBEEF, 4);
      u_core.spm(8'h01, 16'h0282, 16'h1234, 1);
      @(negedge clk_sys);
      chk(buf_valid, 64'hA);
   endtask : load2
   initial begin
      repeat (10) @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      chk({reset_vector, buf_valid}, 0);
      fuse = 1'b0;
      lpm_addr = 16'hF235;
      repeat (4) @(negedge clk_sys);
      chk(reset_vector, 16'h1C00);
      chk({lpm_word_addr, lpm_byte_hi}, {16'h791A, 1'b1});
      $display("reset and byte read done");
      load2;
      eeprom_write = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(buf_valid, 0);
      eeprom_write = 1'b0;
      repeat (3) @(negedge clk_sys);
      load2;
      u_core.spm(8'h83, 16'h0280, 16'hFFFF, 2);
      chk({flash_strobe, rww_read_block, cpu_halt, st}, {3'b110, 8'hC1});
      repeat (3) @(negedge clk_sys);
      chk({flash_op.erase, flash_op.addr[15:7]}, {1'b1, 9'd5});
      wait_done;
      chk({spm_irq, st, buf_valid}, {1'b1, 8'hC0, 64'hA});
      u_core.spm(8'h91, 16'h0000, 16'h0000, 3);
      @(negedge clk_sys);
      chk({rww_read_block, st[6], buf_valid}, 0);
      $display("rww erase done");
      u_core.spm(8'h03, 16'h7300, 16'h0000, 1);
      chk({flash_strobe, cpu_halt}, 2'b11);
      wait_done;
      u_core.spm(8'h11, 16'h0000, 16'h0000, 1);
      u_core.spm(8'h01, 16'h7300, 16'hCAFE, 3);
      u_core.spm(8'h05, 16'h7300, 16'h0000, 4);
      chk({flash_strobe, cpu_halt, rww_read_block}, 3'b111);
      chk({flash_wdata, flash_widx}, {16'hCAFE, 6'h00});
      wait_done;
      @(negedge clk_sys);
      chk({spm_irq, buf_valid}, 0);
      $display("no_read_while_write_area write done");
      u_core.spm(8'h09, 16'hFFFF, 16'h00C0, 1);
      chk({flash_strobe, flash_op.lock, flash_op.addr, cpu_halt}, {2'b11, 16'h0000, 1'b0});
      wait_done;
      $display("lock set done");
      u_core.spm(8'h03, 16'h0280, 16'h0000, 0);
      chk({flash_strobe, st[0]}, 0);
      chk(reset_vector, 16'h1C00);
      $display("arm timeout done");
      wrap_up;
   end
   initial begin
      // over twelve times the expected run length
      #200000;
      error_cnt++;
      wrap_up;
   end
endmodule : flash_self_program_sequencer_bench
`default_nettype wire
